// ===== src/ebpm_pkg.sv
// Shared constants and types for the external bus pin and mode control block.
`default_nettype none
package ebpm_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [29:0] MODE_IDX = 30'h0FFFFFBE;
  localparam logic [29:0] WIDTH_IDX = 30'h0FFFFFC0;
  localparam logic [29:0] WAIT_IDX = 30'h0FFFFFC1;
  localparam logic [29:0] STAT_IDX = 30'h0FFFFFC2;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SEP_BIT = 0;
  localparam int CLKEN_BIT = 8;
  localparam int BUSY_BIT = 0;
  localparam int HOLDAK_BIT = 1;
  localparam logic MODE_RST = 1'h0;
  localparam logic [3:0] WIDTH_RST = 4'hF;
  localparam logic CLKEN_RST = 1'h1;
  localparam logic [2:0] WAIT_RST = 3'h7;
  // ----------------------------------------------------------------
  // Address map of the external area
  // ----------------------------------------------------------------
  localparam int ADDR_W = 26;
  localparam int EXT_TOP_BIT = 24;
  localparam int BLK_LO_BIT = 21;
  localparam int PIN_ADDR_W = 22;
  localparam int UP_ADDR_W = 6;
  localparam logic [2:0] BLK1_CODE = 3'h1;
  localparam logic [2:0] BLK2_CODE = 3'h2;
  localparam logic [2:0] BLK3_CODE = 3'h4;
  localparam logic [1:0] BLK0 = 2'h0;
  localparam logic [1:0] BLK1 = 2'h1;
  localparam logic [1:0] BLK2 = 2'h2;
  localparam logic [1:0] BLK3 = 2'h3;
  localparam logic [3:0] ZERO_WAIT = 4'h0;
  // ----------------------------------------------------------------
  // Bus cycle states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_STRB = 3'h3,
    ST_LAST = 3'h2,
    ST_HOLD = 3'h6
  } ebpm_state_type;
endpackage : ebpm_pkg
`default_nettype wire

// ===== src/ebpm_top.sv
// External bus pin and mode control: APB registers, bus cycle engine and pins.
//
// Overview of operation
// - Multiplexed mode: address then data, strobe, upper.
// - Separate mode: data only, separate lower address.
// - System clock divided by two presented on clock output pin.
// - Internal access floats shared lines in separate mode.
// - Internal access holds upper address outputs low.
// - Internal access keeps every bus strobe inactive.
// - Write to internal ROM area runs external cycle.
// - Read of internal ROM area stays internal.
// - Lowest 16 MB decoded into four blocks.
// - Per-block data width and wait count.
// - Only 22 address outputs; area repeats every 4MB.
// - Mode bit 0: zero multiplexed, one separate.
// - Reset clears mode register to multiplexed.
// - Mode register readable, writable by byte or bit.
// - Wait input stretches external cycles only.
// - Cycle lasts at least five clocks muxed, four separate.
// - 16-bit blocks: even bytes low lane, odd bytes high lane; 8-bit blocks use the low lane only.
`default_nettype none
module ebpm_top #(
  parameter logic [ebpm_pkg::ADDR_W-1:0] ROM_SIZE = 26'h0100000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reqValid,
  input wire logic [ebpm_pkg::ADDR_W-1:0] reqAddr,
  input wire logic reqWrite,
  input wire logic [15:0] reqWdata,
  input wire logic [1:0] reqBe,
  output logic reqAck,
  output logic reqExternal,
  output logic [15:0] reqRdata,
  input wire logic [15:0] adIn,
  output logic [15:0] adOut,
  output logic adOe,
  output logic [15:0] lowAddrOut,
  output logic [ebpm_pkg::UP_ADDR_W-1:0] upAddrOut,
  output logic addrLatchStrobe,
  output logic readStrobe_b,
  output logic writeStrobeLow_b,
  output logic writeStrobeHigh_b,
  output logic busOe,
  output logic systemClockOut,
  input wire logic waitIn_b,
  input wire logic holdRequestIn,
  output logic holdAckOut
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ebpm_pkg::ebpm_state_type st;
    logic sepMode;
    logic [3:0] width;
    logic clkEn;
    logic [11:0] waits;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic cycSep;
    logic cycWr;
    logic cycWide;
    logic [1:0] cycBe;
    logic [ebpm_pkg::ADDR_W-1:0] cycAddr;
    logic [15:0] cycData;
    logic [3:0] waitCnt;
    logic ack;
    logic ext;
    logic [15:0] rd;
    logic [15:0] ad;
    logic adOe;
    logic [15:0] low;
    logic [ebpm_pkg::UP_ADDR_W-1:0] up;
    logic address_latch_strobe;
    logic rd_b;
    logic wr0_b;
    logic wr1_b;
    logic busOe;
    logic clk;
    logic hold_acknowledge_output;
    logic [1:0] waitSync;
    logic [1:0] holdSync;
    logic [31:0] dSync;
  } ebpm_regs_type;

  ebpm_regs_type cur_ff;
  ebpm_regs_type nxt_cur;

  logic [29:0] idx;
  logic setup;
  logic commit;
  logic [1:0] blk;
  logic isExt;
  logic isRom;
  logic goExt;
  logic [15:0] pinData;
  logic [3:0] blkWait;
  // Strobe spans the two-flop latency so read data and the wait input are seen in time.
  localparam logic [3:0] SYNC_LAT = 4'h2;

  assign idx = paddr[31:2];
  assign setup = psel && !penable;
  assign commit = psel && penable && cur_ff.ready;
  assign pinData = cur_ff.dSync[31:16];
  assign blkWait = {1'b0, cur_ff.waits[3*blk +: 3]};
  // Mapped external area, ROM hole at the bottom of it.
  assign isExt = (reqAddr[ebpm_pkg::ADDR_W-1:ebpm_pkg::EXT_TOP_BIT] == 2'h0);
  assign isRom = (reqAddr < ROM_SIZE);
  // ROM writes go out on the bus, ROM reads stay inside.
  assign goExt = isExt && (!isRom || reqWrite);

  // ----------------------------------------------------------------
  // Block decode
  // ----------------------------------------------------------------
  always_comb begin
    blk = ebpm_pkg::BLK0;
    if (reqAddr[23:21] >= ebpm_pkg::BLK3_CODE) begin
      blk = ebpm_pkg::BLK3;
    end else if (reqAddr[23:21] >= ebpm_pkg::BLK2_CODE) begin
      blk = ebpm_pkg::BLK2;
    end else if (reqAddr[23:21] == ebpm_pkg::BLK1_CODE) begin
      blk = ebpm_pkg::BLK1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.waitSync = {cur_ff.waitSync[0], !waitIn_b};
    nxt_cur.holdSync = {cur_ff.holdSync[0], holdRequestIn};
    nxt_cur.dSync = {cur_ff.dSync[15:0], adIn};
    // Toggled flop keeps the pin glitch free; the pin runs at half rate.
    nxt_cur.clk = cur_ff.clkEn && !cur_ff.clk;
    nxt_cur.ack = 1'b0;
    nxt_cur.ready = 1'b0;
    nxt_cur.err = 1'b0;
    if (setup) begin
      nxt_cur.ready = 1'b1;
      nxt_cur.rdata = 32'h0;
      case (idx)
        ebpm_pkg::MODE_IDX: begin
          nxt_cur.rdata[ebpm_pkg::SEP_BIT] = cur_ff.sepMode;
        end
        ebpm_pkg::WIDTH_IDX: begin
          nxt_cur.rdata[3:0] = cur_ff.width;
          nxt_cur.rdata[ebpm_pkg::CLKEN_BIT] = cur_ff.clkEn;
        end
        ebpm_pkg::WAIT_IDX: begin
          nxt_cur.rdata[11:0] = cur_ff.waits;
        end
        ebpm_pkg::STAT_IDX: begin
          nxt_cur.rdata[ebpm_pkg::BUSY_BIT] = (cur_ff.st != ebpm_pkg::ST_IDLE);
          nxt_cur.rdata[ebpm_pkg::HOLDAK_BIT] = cur_ff.hold_acknowledge_output;
        end
        default: begin
          nxt_cur.err = 1'b1;
        end
      endcase
    end
    if (commit && pwrite && pstrb[0]) begin
      case (idx)
        ebpm_pkg::MODE_IDX: begin
          // Only the mode bit is kept; the others are dropped.
          nxt_cur.sepMode = pwdata[ebpm_pkg::SEP_BIT];
        end
        ebpm_pkg::WIDTH_IDX: begin
          nxt_cur.width = pwdata[3:0];
        end
        ebpm_pkg::WAIT_IDX: begin
          nxt_cur.waits[7:0] = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
    if (commit && pwrite && pstrb[1]) begin
      if (idx == ebpm_pkg::WIDTH_IDX) begin
        nxt_cur.clkEn = pwdata[ebpm_pkg::CLKEN_BIT];
      end
      if (idx == ebpm_pkg::WAIT_IDX) begin
        nxt_cur.waits[11:8] = pwdata[11:8];
      end
    end
    case (cur_ff.st)
      ebpm_pkg::ST_IDLE: begin
        // Pins rest: strobes off, upper address low, data floating.
        nxt_cur.address_latch_strobe = 1'b0;
        nxt_cur.rd_b = 1'b1;
        nxt_cur.wr0_b = 1'b1;
        nxt_cur.wr1_b = 1'b1;
        nxt_cur.up = '0;
        nxt_cur.adOe = 1'b0;
        if (cur_ff.holdSync[1]) begin
          nxt_cur.st = ebpm_pkg::ST_HOLD;
          nxt_cur.busOe = 1'b0;
        end else if (reqValid && !cur_ff.ack) begin
          if (!goExt) begin
            nxt_cur.ack = 1'b1;
            nxt_cur.ext = 1'b0;
            nxt_cur.rd = 16'h0;
          end else begin
            // Mode is frozen per cycle, so a late mode write cannot tear it.
            nxt_cur.cycSep = cur_ff.sepMode;
            nxt_cur.cycWr = reqWrite;
            nxt_cur.cycWide = cur_ff.width[blk];
            nxt_cur.cycBe = reqBe;
            nxt_cur.cycAddr = reqAddr;
            nxt_cur.cycData = reqWdata;
            nxt_cur.waitCnt = (blkWait < SYNC_LAT) ? SYNC_LAT : blkWait;
            nxt_cur.up = reqAddr[ebpm_pkg::PIN_ADDR_W-1:16];
            if (cur_ff.sepMode) begin
              nxt_cur.low = reqAddr[15:0];
              nxt_cur.st = ebpm_pkg::ST_STRB;
              nxt_cur.adOe = reqWrite;
              nxt_cur.rd_b = reqWrite;
              nxt_cur.wr0_b = !(reqWrite && (reqBe[0] || !cur_ff.width[blk]));
              nxt_cur.wr1_b = !(reqWrite && reqBe[1] && cur_ff.width[blk]);
            end else begin
              nxt_cur.low = 16'h0;
              nxt_cur.ad = reqAddr[15:0];
              nxt_cur.adOe = 1'b1;
              nxt_cur.address_latch_strobe = 1'b1;
              nxt_cur.st = ebpm_pkg::ST_ADDR;
            end
            if (reqWrite && cur_ff.sepMode) begin
              if (!cur_ff.width[blk] && reqBe == 2'h2) begin
                nxt_cur.ad = {8'h0, reqWdata[15:8]};
              end else begin
                nxt_cur.ad = reqWdata;
              end
            end
          end
        end
      end
      ebpm_pkg::ST_ADDR: begin
        nxt_cur.address_latch_strobe = 1'b0;
        nxt_cur.st = ebpm_pkg::ST_STRB;
        nxt_cur.adOe = cur_ff.cycWr;
        nxt_cur.ad = cur_ff.cycData;
        if (!cur_ff.cycWide && cur_ff.cycBe == 2'h2) begin
          nxt_cur.ad = {8'h0, cur_ff.cycData[15:8]};
        end
        nxt_cur.rd_b = cur_ff.cycWr;
        nxt_cur.wr0_b = !(cur_ff.cycWr && (cur_ff.cycBe[0] || !cur_ff.cycWide));
        nxt_cur.wr1_b = !(cur_ff.cycWr && cur_ff.cycBe[1] && cur_ff.cycWide);
      end
      ebpm_pkg::ST_STRB: begin
        if (cur_ff.waitCnt != ebpm_pkg::ZERO_WAIT) begin
          nxt_cur.waitCnt = cur_ff.waitCnt - 4'h1;
        end else if (!cur_ff.waitSync[1]) begin
          nxt_cur.st = ebpm_pkg::ST_LAST;
          nxt_cur.rd_b = 1'b1;
          nxt_cur.wr0_b = 1'b1;
          nxt_cur.wr1_b = 1'b1;
          if (!cur_ff.cycWide) begin
            nxt_cur.rd = {pinData[7:0], pinData[7:0]};
          end else begin
            nxt_cur.rd = pinData;
          end
        end
      end
      ebpm_pkg::ST_LAST: begin
        nxt_cur.adOe = 1'b0;
        nxt_cur.ack = 1'b1;
        nxt_cur.ext = 1'b1;
        nxt_cur.st = ebpm_pkg::ST_IDLE;
      end
      ebpm_pkg::ST_HOLD: begin
        nxt_cur.hold_acknowledge_output = cur_ff.holdSync[1];
        if (!cur_ff.holdSync[1] && !cur_ff.hold_acknowledge_output) begin
          nxt_cur.busOe = 1'b1;
          nxt_cur.st = ebpm_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_cur.st = ebpm_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
      cur_ff.st <= ebpm_pkg::ST_IDLE;
      cur_ff.sepMode <= ebpm_pkg::MODE_RST;
      cur_ff.width <= ebpm_pkg::WIDTH_RST;
      cur_ff.clkEn <= ebpm_pkg::CLKEN_RST;
      cur_ff.waits <= {4{ebpm_pkg::WAIT_RST}};
      cur_ff.rd_b <= 1'b1;
      cur_ff.wr0_b <= 1'b1;
      cur_ff.wr1_b <= 1'b1;
      cur_ff.busOe <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = cur_ff.rdata;
  assign pready = cur_ff.ready;
  assign pslverr = cur_ff.err;
  assign reqAck = cur_ff.ack;
  assign reqExternal = cur_ff.ext;
  assign reqRdata = cur_ff.rd;
  assign adOut = cur_ff.ad;
  assign adOe = cur_ff.adOe;
  assign lowAddrOut = cur_ff.low;
  assign upAddrOut = cur_ff.up;
  assign addrLatchStrobe = cur_ff.address_latch_strobe;
  assign readStrobe_b = cur_ff.rd_b;
  assign writeStrobeLow_b = cur_ff.wr0_b;
  assign writeStrobeHigh_b = cur_ff.wr1_b;
  assign busOe = cur_ff.busOe;
  assign systemClockOut = cur_ff.clk;
  assign holdAckOut = cur_ff.hold_acknowledge_output;
endmodule : ebpm_top
`default_nettype wire

// ===== verif/ebpm_checker.sv
// Concurrent assertions on the ports of the external bus pin and mode control block.
`default_nettype none
module ebpm_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [ebpm_pkg::ADDR_W-1:0] reqAddr,
  input wire logic reqAck,
  input wire logic reqExternal,
  input wire logic [15:0] adOut,
  input wire logic adOe,
  input wire logic [15:0] lowAddrOut,
  input wire logic [ebpm_pkg::UP_ADDR_W-1:0] upAddrOut,
  input wire logic addrLatchStrobe,
  input wire logic readStrobe_b,
  input wire logic writeStrobeLow_b,
  input wire logic writeStrobeHigh_b,
  input wire logic busOe,
  input wire logic systemClockOut,
  input wire logic holdAckOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence s_quiet3;
    !reqAck [*3];
  endsequence
  sequence s_quiet2;
    !reqAck [*2];
  endsequence
  // The clock output is checked every cycle after reset; the bench never clears the enable.
  AST_SYSTEM_CLOCK_OUTPUT: assert property ($past(rst_b) |-> systemClockOut != $past(systemClockOut))
    else $error("clock output stalled");
  AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  AST_MUX_ADDR: assert property (addrLatchStrobe |-> adOe && lowAddrOut == 16'h0 &&
    adOut == reqAddr[15:0] && upAddrOut == reqAddr[21:16]) else $error("mux address wrong");
  AST_SEP_ADDR: assert property ($fell(readStrobe_b) && !$past(addrLatchStrobe) |->
    lowAddrOut == reqAddr[15:0] && !adOe) else $error("separate address wrong");
  AST_MUX_LEN: assert property (addrLatchStrobe |-> s_quiet3)
    else $error("mux cycle too short");
  AST_RD_LEN: assert property ($fell(readStrobe_b) |-> s_quiet2 ##[1:40] reqAck && reqExternal)
    else $error("read cycle length wrong");
  AST_WR_DRIVE: assert property (!writeStrobeLow_b |-> adOe && busOe && !addrLatchStrobe)
    else $error("write data not driven");
  AST_INT_QUIET: assert property (reqAck && !reqExternal |-> readStrobe_b &&
    writeStrobeLow_b && writeStrobeHigh_b && !adOe && upAddrOut == 6'h0)
    else $error("pins active on internal access");
  AST_HOLD_OFF: assert property (holdAckOut |-> !busOe && !adOe && readStrobe_b)
    else $error("bus driven during hold");
  AST_HOLD_EDGE: assert property ($changed(holdAckOut) |-> !busOe && !$past(busOe))
    else $error("hold acknowledge out of order");
endmodule : ebpm_checker
bind ebpm_top ebpm_checker chk_u (.*);
`default_nettype wire

// ===== verif/ebpm_ext_mem.sv
// Behavioural external memory on the far side of the bus pins.
`default_nettype none
module ebpm_ext_mem (
  input wire logic clk_sys,
  input wire logic sepMode,
  input wire logic slow,
  input wire logic [15:0] adOut,
  input wire logic adOe,
  input wire logic [15:0] lowAddrOut,
  input wire logic addrLatchStrobe,
  input wire logic readStrobe_b,
  input wire logic writeStrobeLow_b,
  input wire logic writeStrobeHigh_b,
  output logic [15:0] adIn,
  output logic waitIn_b
);
  logic [15:0] mem [16];
  logic [15:0] lat, last;
  logic [3:0] cnt, idx;
  // A released line shows the inverse of its last level so a stale value never passes.
  assign idx = sepMode ? lowAddrOut[4:1] : lat[4:1];
  assign adIn = adOe ? adOut : (!readStrobe_b ? mem[idx] : ~last);
  assign waitIn_b = !(slow && !readStrobe_b && cnt != 4'hC);
  always @(posedge clk_sys) begin
    last <= adIn;
    cnt <= readStrobe_b ? 4'h0 : cnt + {3'h0, cnt != 4'hC};
    if (addrLatchStrobe) begin
      lat <= adOut;
    end
    if (!writeStrobeLow_b) begin
      mem[idx][7:0] <= adOut[7:0];
    end
    if (!writeStrobeHigh_b) begin
      mem[idx][15:8] <= adOut[15:8];
    end
  end
endmodule : ebpm_ext_mem
`default_nettype wire

// ===== verif/ebpm_top_test.sv
// Self-checking testbench for the external bus pin and mode control block.
`default_nettype none
module ebpm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MODE_A = {ebpm_pkg::MODE_IDX, 2'h0};
  localparam logic [31:0] WAIT_A = {ebpm_pkg::WAIT_IDX, 2'h0};
  localparam logic [31:0] WIDTH_A = {ebpm_pkg::WIDTH_IDX, 2'h0};
  logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic reqValid = 1'b0, reqWrite = 1'b0, holdRequestIn = 1'b0, sepMode = 1'b0, slow = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] reqBe = 2'h3;
  logic [ebpm_pkg::ADDR_W-1:0] reqAddr = 26'h0;
  logic [15:0] reqWdata = 16'h0, reqRdata, adIn, adOut, lowAddrOut, d;
  logic [ebpm_pkg::UP_ADDR_W-1:0] upAddrOut;
  logic pready, pslverr, reqAck, reqExternal, adOe, addrLatchStrobe, readStrobe_b;
  logic writeStrobeLow_b, writeStrobeHigh_b, busOe, systemClockOut, waitIn_b, holdAckOut, e, x;
  int c, bad_count = 0, check_count = 0;
  ebpm_top dut_u (.*);
  ebpm_ext_mem mem_u (.*);
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= {3'h0, wr};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic req(input logic [25:0] a, input logic wr, input logic [15:0] wd);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= wr;
    reqWdata <= wd;
    c = -1;
    do begin
      @(posedge clk_sys);
      c++;
    end while (reqAck !== 1'b1);
    d = reqRdata;
    x = reqExternal;
    reqValid <= 1'b0;
  endtask : req
  task automatic t_regs;
    apb(1'b0, MODE_A, 32'h0);
    chk("mode reset", 32'h0, q);
    apb(1'b0, WAIT_A, 32'h0);
    chk("wait reset", 32'hFFF, q);
    apb(1'b1, MODE_A, 32'hFF);
    apb(1'b0, MODE_A, 32'h0);
    chk("mode set", 32'h1, q);
    apb(1'b1, MODE_A, 32'hFE);
    apb(1'b0, MODE_A, 32'h0);
    chk("mode clear", 32'h0, q);
    apb(1'b1, WAIT_A, 32'hFC7);
    apb(1'b0, 32'h3FFFFF0C, 32'h0);
    chk("unmapped", 32'h1, e);
  endtask : t_regs
  task automatic t_mux;
    req(26'h0000040, 1'b1, 16'hA55A);
    chk("rom write", 32'h1, x);
    chk("mux write len", 32'hB, c);
    req(26'h0000040, 1'b0, 16'h0);
    chk("rom read", 32'h0, x);
    chk("internal len", 32'h1, c);
    req(26'h0E00040, 1'b0, 16'h0);
    chk("mux read", 32'hA55A, d);
    chk("mux read len", 32'hB, c);
    req(26'h3000000, 1'b1, 16'h0);
    chk("peripheral", 32'h0, x);
  endtask : t_mux
  task automatic t_sep;
    apb(1'b1, MODE_A, 32'h1);
    sepMode <= 1'b1;
    req(26'h0200042, 1'b1, 16'h1234);
    chk("block1 len", 32'h5, c);
    req(26'h0100044, 1'b1, 16'h5678);
    chk("block0 len", 32'hA, c);
    slow <= 1'b1;
    req(26'h0600042, 1'b0, 16'h0);
    chk("alias read", 32'h1234, d);
    chk("stretched", 32'h1, c > 10);
    slow <= 1'b0;
    apb(1'b1, MODE_A, 32'h0);
    sepMode <= 1'b0;
  endtask : t_sep
  task automatic t_byte;
    apb(1'b0, WIDTH_A, 32'h0);
    chk("width reset", 32'h10F, q);
    apb(1'b1, WIDTH_A, 32'hD);
    apb(1'b0, WIDTH_A, 32'h0);
    chk("width low lane only", 32'h10D, q);
    reqBe <= 2'h2;
    req(26'h0200046, 1'b1, 16'hBE00);
    chk("byte write len", 32'h6, c);
    req(26'h0200046, 1'b0, 16'h0);
    chk("byte read", 32'hBEBE, d);
    req(26'h0100040, 1'b1, 16'h3C00);
    req(26'h0E00040, 1'b0, 16'h0);
    chk("high lane", 32'h3C5A, d);
    reqBe <= 2'h3;
  endtask : t_byte
  task automatic t_hold;
    @(posedge clk_sys);
    holdRequestIn <= 1'b1;
    for (int i = 0; i < 10 && holdAckOut !== 1'b1; i++) @(posedge clk_sys);
    chk("hold ack", 32'h1, holdAckOut);
    chk("hold release", 32'h0, busOe);
    holdRequestIn <= 1'b0;
    for (int i = 0; i < 10 && busOe !== 1'b1; i++) @(posedge clk_sys);
    chk("hold end", 32'h0, holdAckOut);
    chk("bus back", 32'h1, busOe);
  endtask : t_hold
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_mux();
    t_sep();
    t_byte();
    t_hold();
    wrap_up();
  end
  // The span is many times the few hundred cycles that the scenarios need.
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule : ebpm_top_test
`default_nettype wire
